/* hdl/nav_codec_pkg.sv */
// Packet identifiers, payload lengths and field offsets for the navigation payload codec
package nav_codec_pkg;
   localparam logic [7:0] ID_ANG_VEL = 8'h2a;
   localparam logic [7:0] ID_ANG_ACC = 8'h2b;
   localparam logic [7:0] ID_POS_VEL = 8'h2c;
   localparam logic [7:0] ID_POS = 8'h2d;
   localparam logic [7:0] ID_VEL = 8'h2e;
   localparam logic [7:0] ID_BODY_VEL = 8'h2f;
   localparam logic [7:0] ID_HEADING = 8'h30;
   localparam logic [7:0] LEN_ANG = 8'h0c;
   localparam logic [7:0] LEN_POS_VEL = 8'h3c;
   localparam logic [7:0] LEN_POS = 8'h24;
   localparam logic [7:0] LEN_VEL = 8'h18;
   localparam logic [7:0] LEN_BODY_VEL = 8'h10;
   localparam logic [7:0] LEN_HEADING = 8'h08;
   // Byte offsets
   localparam int OFS_0 = 0;
   localparam int OFS_4 = 4;
   localparam int OFS_8 = 8;
   localparam int OFS_12 = 12;
   localparam int OFS_16 = 16;
   localparam int OFS_20 = 20;
   localparam int OFS_24 = 24;
   localparam int OFS_28 = 28;
   localparam int OFS_32 = 32;
   localparam int OFS_36 = 36;
   localparam int OFS_40 = 40;
   localparam int OFS_44 = 44;
   localparam int OFS_48 = 48;
   localparam int OFS_52 = 52;
   localparam int OFS_56 = 56;
   localparam int MAX_LEN = 60;
endpackage

/* hdl/nav_packet_payload_codec.sv */
// Payload encoder for rate packets and decoder for external aiding packets
// Function
// [R1] Id 42 is sent as 12 bytes holding angular rate X, Y, Z as fp32 at offsets 0, 4, 8.
// [R2] Id 43 is sent as 12 bytes holding angular acceleration X, Y, Z as fp32 at offsets 0, 4, 8.
// [R3] Id 44 is 60 bytes starting with latitude, longitude and height as fp64 at offsets 0, 8, 16.
// [R4] Id 44 continues with NED velocity fp32 at 24..32 and six fp32 deviations at 36..56.
// [R5] Id 45 is 36 bytes: lat, lon, height fp64 at 0, 8, 16 and their deviations fp32 at 24, 28, 32.
// [R6] Id 46 is 24 bytes: NED velocity fp32 at 0, 4, 8 and deviations at 12, 16, 20.
// [R7] Id 47 is 16 bytes: body velocity fp32 at 0, 4, 8 and one shared deviation at 12.
// [R8] Id 48 is 8 bytes: heading fp32 at 0 and its deviation at 4.
// [R9] An aiding packet whose length does not match its identifier is dropped with no field output.
`timescale 1ns/1ns
module nav_packet_payload_codec
(
   input wire logic ref_clk,
   input wire logic resetn,
   // Encoder request
   input wire logic tx_req_rate,
   input wire logic tx_req_accel,
   output logic tx_busy,
   input wire logic [31:0] ang_x,
   input wire logic [31:0] ang_y,
   input wire logic [31:0] ang_z,
   // Encoder byte stream
   output logic tx_start,
   output logic [7:0] tx_id,
   output logic [7:0] tx_len,
   output logic tx_valid,
   output logic [7:0] tx_data,
   output logic tx_last,
   input wire logic tx_ready,
   // Decoder byte stream
   input wire logic rx_start,
   input wire logic [7:0] rx_id,
   input wire logic [7:0] rx_len,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_last,
   // Decoded aiding
   output logic [63:0] aid_lat,
   output logic [63:0] aid_lon,
   output logic [63:0] aid_hgt,
   output logic [31:0] aid_vel_n,
   output logic [31:0] aid_vel_e,
   output logic [31:0] aid_vel_d,
   output logic [31:0] aid_sd_lat,
   output logic [31:0] aid_sd_lon,
   output logic [31:0] aid_sd_hgt,
   output logic [31:0] aid_sd_vn,
   output logic [31:0] aid_sd_ve,
   output logic [31:0] aid_sd_vd,
   output logic [31:0] aid_body_x,
   output logic [31:0] aid_body_y,
   output logic [31:0] aid_body_z,
   output logic [31:0] aid_sd_body,
   output logic [31:0] aid_heading,
   output logic [31:0] aid_sd_heading,
   output logic aid_pos_vel_stb,
   output logic aid_pos_stb,
   output logic aid_vel_stb,
   output logic aid_body_stb,
   output logic aid_heading_stb,
   output logic rx_drop
);
   // ----------------------------------------
   // Encoder
   // ----------------------------------------
   logic [95:0] tx_shift;
   logic [7:0] tx_cnt;
   logic tx_run;
   assign tx_busy = tx_run;
   assign tx_valid = tx_run;
   assign tx_data = tx_shift[7:0];
   assign tx_last = tx_run && (tx_cnt == nav_codec_pkg::LEN_ANG - 8'h01);

   // Little endian: fp32 X occupies bytes 0..3, Y 4..7, Z 8..11
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tx_run <= 1'b0;
         tx_shift <= '0;
         tx_cnt <= 8'h00;
         tx_id <= 8'h00;
         tx_len <= 8'h00;
         tx_start <= 1'b0;
      end
      else
      begin
         tx_start <= 1'b0;
         if (!tx_run && (tx_req_rate || tx_req_accel))
         begin
            tx_run <= 1'b1;
            tx_start <= 1'b1;
            tx_cnt <= 8'h00;
            tx_shift <= {ang_z, ang_y, ang_x}; // see [R1]
            tx_id <= tx_req_rate ? nav_codec_pkg::ID_ANG_VEL : nav_codec_pkg::ID_ANG_ACC; // see [R1] see [R2]
            tx_len <= nav_codec_pkg::LEN_ANG; // see [R2]
         end
         else if (tx_run && tx_ready)
         begin
            tx_shift <= {8'h00, tx_shift[95:8]};
            tx_cnt <= tx_cnt + 8'h01;
            if (tx_last)
               tx_run <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Decoder
   // ----------------------------------------
   logic [7:0] rx_buf [0:nav_codec_pkg::MAX_LEN-1];
   logic [7:0] rx_ptr;
   logic [7:0] rx_cur_id;
   logic rx_ok;
   logic rx_act;
   logic [7:0] exp_len;

   always_comb
   begin
      case (rx_id)
         nav_codec_pkg::ID_POS_VEL: exp_len = nav_codec_pkg::LEN_POS_VEL;
         nav_codec_pkg::ID_POS: exp_len = nav_codec_pkg::LEN_POS;
         nav_codec_pkg::ID_VEL: exp_len = nav_codec_pkg::LEN_VEL;
         nav_codec_pkg::ID_BODY_VEL: exp_len = nav_codec_pkg::LEN_BODY_VEL;
         nav_codec_pkg::ID_HEADING: exp_len = nav_codec_pkg::LEN_HEADING;
         default: exp_len = 8'h00;
      endcase
   end

   function automatic logic [31:0] w32(input int o);
      w32 = {rx_buf[o+3], rx_buf[o+2], rx_buf[o+1], rx_buf[o]};
   endfunction
   function automatic logic [63:0] w64(input int o);
      w64 = {w32(o+4), w32(o)};
   endfunction

   // Byte capture; last byte goes straight into the buffer view via a one-cycle-later strobe
   logic rx_done;
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rx_ptr <= 8'h00;
         rx_cur_id <= 8'h00;
         rx_ok <= 1'b0;
         rx_act <= 1'b0;
         rx_done <= 1'b0;
         rx_drop <= 1'b0;
      end
      else
      begin
         rx_done <= 1'b0;
         rx_drop <= 1'b0;
         if (rx_start)
         begin
            rx_act <= 1'b1;
            rx_ptr <= 8'h00;
            rx_cur_id <= rx_id;
            rx_ok <= (exp_len != 8'h00) && (rx_len == exp_len); // see [R9]
         end
         else if (rx_act && rx_valid)
         begin
            rx_ptr <= rx_ptr + 8'h01;
            if (rx_last)
            begin
               rx_act <= 1'b0;
               // Byte count must match too, or fields would be stale
               if (rx_ok && (rx_ptr + 8'h01 == rx_len)) // see [R9]
                  rx_done <= 1'b1;
               else
                  rx_drop <= 1'b1; // see [R9]
            end
         end
      end
   end

   // No reset on storage; contents are only used after a full packet
   always_ff @(posedge ref_clk)
   begin
      if (rx_act && rx_valid && rx_ptr < 8'(nav_codec_pkg::MAX_LEN))
         rx_buf[rx_ptr[5:0]] <= rx_data;
   end

   // Field unpack on a good packet only
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         {aid_lat, aid_lon, aid_hgt} <= '0;
         {aid_vel_n, aid_vel_e, aid_vel_d} <= '0;
         {aid_sd_lat, aid_sd_lon, aid_sd_hgt, aid_sd_vn, aid_sd_ve, aid_sd_vd} <= '0;
         {aid_body_x, aid_body_y, aid_body_z, aid_sd_body, aid_heading, aid_sd_heading} <= '0;
         {aid_pos_vel_stb, aid_pos_stb, aid_vel_stb, aid_body_stb, aid_heading_stb} <= '0;
      end
      else
      begin
         {aid_pos_vel_stb, aid_pos_stb, aid_vel_stb, aid_body_stb, aid_heading_stb} <= '0;
         if (rx_done)
         begin
            case (rx_cur_id)
               nav_codec_pkg::ID_POS_VEL:
               begin
                  aid_lat <= w64(nav_codec_pkg::OFS_0); // see [R3]
                  aid_lon <= w64(nav_codec_pkg::OFS_8); // see [R3]
                  aid_hgt <= w64(nav_codec_pkg::OFS_16); // see [R3]
                  aid_vel_n <= w32(nav_codec_pkg::OFS_24); // see [R4]
                  aid_vel_e <= w32(nav_codec_pkg::OFS_28); // see [R4]
                  aid_vel_d <= w32(nav_codec_pkg::OFS_32); // see [R4]
                  aid_sd_lat <= w32(nav_codec_pkg::OFS_36); // see [R4]
                  aid_sd_lon <= w32(nav_codec_pkg::OFS_40); // see [R4]
                  aid_sd_hgt <= w32(nav_codec_pkg::OFS_44); // see [R4]
                  aid_sd_vn <= w32(nav_codec_pkg::OFS_48); // see [R4]
                  aid_sd_ve <= w32(nav_codec_pkg::OFS_52); // see [R4]
                  aid_sd_vd <= w32(nav_codec_pkg::OFS_56); // see [R4]
                  aid_pos_vel_stb <= 1'b1;
               end
               nav_codec_pkg::ID_POS:
               begin
                  aid_lat <= w64(nav_codec_pkg::OFS_0); // see [R5]
                  aid_lon <= w64(nav_codec_pkg::OFS_8); // see [R5]
                  aid_hgt <= w64(nav_codec_pkg::OFS_16); // see [R5]
                  aid_sd_lat <= w32(nav_codec_pkg::OFS_24); // see [R5]
                  aid_sd_lon <= w32(nav_codec_pkg::OFS_28); // see [R5]
                  aid_sd_hgt <= w32(nav_codec_pkg::OFS_32); // see [R5]
                  aid_pos_stb <= 1'b1;
               end
               nav_codec_pkg::ID_VEL:
               begin
                  aid_vel_n <= w32(nav_codec_pkg::OFS_0); // see [R6]
                  aid_vel_e <= w32(nav_codec_pkg::OFS_4); // see [R6]
                  aid_vel_d <= w32(nav_codec_pkg::OFS_8); // see [R6]
                  aid_sd_vn <= w32(nav_codec_pkg::OFS_12); // see [R6]
                  aid_sd_ve <= w32(nav_codec_pkg::OFS_16); // see [R6]
                  aid_sd_vd <= w32(nav_codec_pkg::OFS_20); // see [R6]
                  aid_vel_stb <= 1'b1;
               end
               nav_codec_pkg::ID_BODY_VEL:
               begin
                  aid_body_x <= w32(nav_codec_pkg::OFS_0); // see [R7]
                  aid_body_y <= w32(nav_codec_pkg::OFS_4); // see [R7]
                  aid_body_z <= w32(nav_codec_pkg::OFS_8); // see [R7]
                  aid_sd_body <= w32(nav_codec_pkg::OFS_12); // see [R7]
                  aid_body_stb <= 1'b1;
               end
               nav_codec_pkg::ID_HEADING:
               begin
                  aid_heading <= w32(nav_codec_pkg::OFS_0); // see [R8]
                  aid_sd_heading <= w32(nav_codec_pkg::OFS_4); // see [R8]
                  aid_heading_stb <= 1'b1;
               end
               default:
               begin
               end
            endcase
         end
      end
   end
endmodule

/* tb/nav_host_model.sv */
// Host model: sends aiding frames, sinks rate frames with stalls
`timescale 1ns/1ns
module nav_host_model
(
   input wire logic ref_clk,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready = 1'b0,
   output logic rx_start = 1'b0,
   output logic [7:0] rx_id = 8'h00,
   output logic [7:0] rx_len = 8'h00,
   output logic rx_valid = 1'b0,
   output logic [7:0] rx_data = 8'h5a,
   output logic rx_last = 1'b0
);
   logic [7:0] q [$];
   // Stall every other cycle so a byte must be held
   always @(posedge ref_clk)
   begin
      if (tx_valid && tx_ready)
         q.push_back(tx_data);
      tx_ready <= ~tx_ready;
   end
   // Bytes back to back after the start cycle; released data line inverts to expose stale reads
   task automatic send(input logic [7:0] id, input logic [7:0] len, input int n);
      rx_start <= 1'b1;
      rx_id <= id;
      rx_len <= len;
      for (int k = 0; k < n; k++)
      begin
         @(posedge ref_clk);
         rx_start <= 1'b0;
         rx_valid <= 1'b1;
         rx_data <= 8'(k * 7 + id);
         rx_last <= (k == n - 1);
      end
      @(posedge ref_clk);
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      rx_data <= ~rx_data;
   endtask
endmodule

/* tb/nav_packet_payload_codec_assertions.sv */
// Port-level checks of the navigation payload codec
`timescale 1ns/1ns
module nav_packet_payload_codec_assertions
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic tx_req_rate,
   input wire logic tx_req_accel,
   input wire logic tx_busy,
   input wire logic tx_start,
   input wire logic [7:0] tx_id,
   input wire logic [7:0] tx_len,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   input wire logic tx_ready,
   input wire logic rx_start,
   input wire logic [7:0] rx_id,
   input wire logic [7:0] rx_len,
   input wire logic rx_valid,
   input wire logic rx_last,
   input wire logic [63:0] aid_lat,
   input wire logic [31:0] aid_heading,
   input wire logic aid_pos_vel_stb,
   input wire logic aid_pos_stb,
   input wire logic aid_vel_stb,
   input wire logic aid_body_stb,
   input wire logic aid_heading_stb,
   input wire logic rx_drop
);
   // ----
   // Helpers
   // ----
   logic [3:0] acc_cnt;
   wire logic any_stb = aid_pos_vel_stb | aid_pos_stb | aid_vel_stb | aid_body_stb | aid_heading_stb;
   always_ff @(posedge ref_clk or negedge resetn)
      if (!resetn)
         acc_cnt <= 4'h0;
      else if (tx_valid && tx_ready)
         acc_cnt <= tx_last ? 4'h0 : acc_cnt + 4'h1;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   sequence s_hdg_head;
      rx_start && rx_id == 8'h30 && rx_len == 8'h08;
   endsequence
   sequence s_hdg_bytes;
      (rx_valid && !rx_last && !rx_start)[*7] ##1 (rx_valid && rx_last);
   endsequence
   chk_rate_take: assert property (!tx_busy && tx_req_rate |=>
      tx_start && tx_id == 8'h2a && tx_len == 8'h0c)
      else $error("rate frame header wrong");
   chk_accel_take: assert property (!tx_busy && !tx_req_rate && tx_req_accel |=>
      tx_start && tx_id == 8'h2b)
      else $error("accel frame header wrong");
   chk_byte_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
      else $error("stalled byte changed");
   chk_frame_end: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid)
      else $error("stream ran past last byte");
   chk_twelve_bytes: assert property (tx_valid && tx_last |-> acc_cnt == 4'hb)
      else $error("frame is not twelve bytes");
   // Fields land two edges after the last byte: buffer write, then unpack
   chk_hdg_strobe: assert property (s_hdg_head ##1 s_hdg_bytes |-> ##2 aid_heading_stb)
      else $error("heading frame not delivered");
   chk_hdg_change: assert property ($changed(aid_heading) |-> aid_heading_stb)
      else $error("heading moved without strobe");
   chk_lat_change: assert property ($changed(aid_lat) |-> aid_pos_vel_stb || aid_pos_stb)
      else $error("latitude moved without strobe");
   chk_drop_quiet: assert property (rx_drop |-> !any_stb ##1 !any_stb)
      else $error("strobe with dropped frame");
   chk_stb_cause: assert property (any_stb |-> $past(rx_valid && rx_last, 2))
      else $error("strobe without frame end");
   chk_drop_cause: assert property (rx_drop |-> $past(rx_valid && rx_last))
      else $error("drop without frame end");
endmodule

/* tb/nav_packet_payload_codec_tb_top.sv */
// Self-checking bench of the navigation payload codec
`timescale 1ns/1ns
module nav_packet_payload_codec_tb_top;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic tx_req_rate = 1'b0;
   logic tx_req_accel = 1'b0;
   logic [31:0] ang_x = 32'h0, ang_y = 32'h0, ang_z = 32'h0;
   logic tx_busy, tx_start, tx_valid, tx_last, tx_ready, rx_start, rx_valid, rx_last, rx_drop;
   logic [7:0] tx_id, tx_len, tx_data, rx_id, rx_len, rx_data;
   logic [63:0] aid_lat, aid_lon, aid_hgt;
   logic [31:0] aid_vel_n, aid_vel_e, aid_vel_d, aid_sd_lat, aid_sd_lon, aid_sd_hgt, aid_sd_vn, aid_sd_ve;
   logic [31:0] aid_sd_vd, aid_body_x, aid_body_y, aid_body_z, aid_sd_body, aid_heading, aid_sd_heading;
   logic aid_pos_vel_stb, aid_pos_stb, aid_vel_stb, aid_body_stb, aid_heading_stb;
   int error_cnt = 0;
   int comparisons = 0;
   always #20 ref_clk = ~ref_clk;
   nav_packet_payload_codec i_dut (.ref_clk, .resetn, .tx_req_rate, .tx_req_accel, .tx_busy, .ang_x, .ang_y,
      .ang_z, .tx_start, .tx_id, .tx_len, .tx_valid, .tx_data, .tx_last, .tx_ready, .rx_start, .rx_id, .rx_len,
      .rx_valid, .rx_data, .rx_last, .aid_lat, .aid_lon, .aid_hgt, .aid_vel_n, .aid_vel_e, .aid_vel_d,
      .aid_sd_lat, .aid_sd_lon, .aid_sd_hgt, .aid_sd_vn, .aid_sd_ve, .aid_sd_vd, .aid_body_x, .aid_body_y,
      .aid_body_z, .aid_sd_body, .aid_heading, .aid_sd_heading, .aid_pos_vel_stb, .aid_pos_stb, .aid_vel_stb,
      .aid_body_stb, .aid_heading_stb, .rx_drop);
   nav_host_model i_host (.ref_clk, .tx_valid, .tx_data, .tx_ready, .rx_start, .rx_id, .rx_len, .rx_valid,
      .rx_data, .rx_last);
   // ----
   // Shared tasks
   // ----
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Little-endian view of the host byte pattern
   function automatic logic [63:0] f(input logic [7:0] id, input int o, input int w);
      f = 64'h0;
      for (int k = 0; k < w; k++)
         f[8*k +: 8] = 8'((o + k) * 7 + id);
   endfunction
   // Drop pulses one edge after the last byte, field strobes one edge later
   task automatic t_rx(input logic [7:0] id, input logic [7:0] len, input int n, input logic [4:0] stb);
      logic drop;
      logic [5:0] seen;
      i_host.send(id, len, n);
      #1;
      drop = rx_drop;
      @(posedge ref_clk);
      #1;
      seen = {aid_pos_vel_stb, aid_pos_stb, aid_vel_stb, aid_body_stb, aid_heading_stb, drop};
      chk(seen, {stb, stb == 5'h00});
      @(posedge ref_clk);
   endtask
   // Rate wins when both requests are high
   task automatic t_tx(input logic rate);
      logic [95:0] v;
      v = rate ? 96'h3f80_0001_4000_0002_c0a0_0003 : 96'h1234_5678_9abc_def0_0102_0304;
      i_host.q.delete();
      {ang_z, ang_y, ang_x} <= v;
      tx_req_rate <= rate;
      tx_req_accel <= 1'b1;
      @(posedge ref_clk);
      tx_req_rate <= 1'b0;
      tx_req_accel <= 1'b0;
      #1;
      chk({tx_start, tx_busy}, 2'b11);
      chk(tx_id, rate ? 8'h2a : 8'h2b);
      chk(tx_len, 8'h0c);
      for (int i = 0; i < 60 && i_host.q.size() < 12; i++)
         @(posedge ref_clk);
      chk(64'(i_host.q.size()), 64'h0c);
      if (i_host.q.size() != 12)
         summarize();
      for (int k = 0; k < 12; k++)
         chk(i_host.q[k], v[8*k +: 8]);
      $display("t_tx done");
   endtask
   task automatic t_rx_aid();
      t_rx(8'h2c, 8'h3c, 60, 5'h10);
      chk(aid_lat, f(8'h2c, 0, 8));
      chk(aid_lon, f(8'h2c, 8, 8));
      chk(aid_hgt, f(8'h2c, 16, 8));
      chk({aid_vel_e, aid_vel_n}, f(8'h2c, 24, 8));
      chk({aid_sd_lat, aid_vel_d}, f(8'h2c, 32, 8));
      chk({aid_sd_hgt, aid_sd_lon}, f(8'h2c, 40, 8));
      chk({aid_sd_ve, aid_sd_vn}, f(8'h2c, 48, 8));
      chk(aid_sd_vd, f(8'h2c, 56, 4));
      t_rx(8'h2d, 8'h24, 36, 5'h08);
      t_rx(8'h2e, 8'h18, 24, 5'h04);
      t_rx(8'h2f, 8'h10, 16, 5'h02);
      t_rx(8'h30, 8'h08, 8, 5'h01);
      chk(aid_lat, f(8'h2d, 0, 8));
      chk(aid_lon, f(8'h2d, 8, 8));
      chk(aid_hgt, f(8'h2d, 16, 8));
      chk({aid_sd_lon, aid_sd_lat}, f(8'h2d, 24, 8));
      chk(aid_sd_hgt, f(8'h2d, 32, 4));
      chk({aid_vel_e, aid_vel_n}, f(8'h2e, 0, 8));
      chk({aid_sd_vn, aid_vel_d}, f(8'h2e, 8, 8));
      chk({aid_sd_vd, aid_sd_ve}, f(8'h2e, 16, 8));
      chk({aid_body_y, aid_body_x}, f(8'h2f, 0, 8));
      chk({aid_sd_body, aid_body_z}, f(8'h2f, 8, 8));
      chk({aid_sd_heading, aid_heading}, f(8'h30, 0, 8));
      $display("t_rx_aid done");
   endtask
   // Wrong length, short frame, unknown id; heading must hold
   task automatic t_rx_bad();
      t_rx(8'h30, 8'h09, 9, 5'h00);
      t_rx(8'h30, 8'h08, 7, 5'h00);
      t_rx(8'h31, 8'h08, 8, 5'h00);
      chk({aid_sd_heading, aid_heading}, f(8'h30, 0, 8));
      $display("t_rx_bad done");
   endtask
   task automatic summarize();
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      repeat (6) @(posedge ref_clk);
      resetn <= 1'b1;
      t_tx(1'b1);
      t_tx(1'b0);
      t_rx_aid();
      t_rx_bad();
      summarize();
   end
endmodule
bind nav_packet_payload_codec nav_packet_payload_codec_assertions i_chk (.ref_clk, .resetn, .tx_req_rate,
   .tx_req_accel, .tx_busy, .tx_start, .tx_id, .tx_len, .tx_valid, .tx_data, .tx_last, .tx_ready, .rx_start,
   .rx_id, .rx_len, .rx_valid, .rx_last, .aid_lat, .aid_heading, .aid_pos_vel_stb, .aid_pos_stb, .aid_vel_stb,
   .aid_body_stb, .aid_heading_stb, .rx_drop);
